// ---- cds_pkg.sv ----
// Package: shared constants and types of the sampling readout sequencer
package cds_pkg;
  localparam int CDS_DATA_W = 16;
  localparam int CDS_OFS_W = 9;
  localparam int CDS_GAIN_W = 6;
  localparam int CDS_LATENCY = 3;
  localparam int CDS_FIFO_DEPTH = 8;
  // Register byte offsets
  localparam logic [11:0] CDS_OFS_CFG = 12'h000;
  localparam logic [11:0] CDS_OFS_MUX = 12'h004;
  localparam logic [11:0] CDS_OFS_GAIN0 = 12'h008;
  localparam logic [11:0] CDS_OFS_OFFS0 = 12'h018;
  localparam logic [11:0] CDS_OFS_STAT = 12'h028;
  localparam logic [11:0] CDS_OFS_SAMP = 12'h02C;
  // Configuration fields
  localparam int CDS_CFG_POWER = 0;
  localparam int CDS_CFG_SHA = 3;
  localparam int CDS_CFG_ONEBYTE = 4;
  localparam int CDS_CFG_SINGLE = 6;
  localparam int CDS_MUX_REV = 4;
  localparam logic [8:0] CDS_CFG_RST = 9'h000;
  localparam logic [8:0] CDS_MUX_RST = 9'h000;
  localparam logic [31:0] CDS_ERR_WORD = 32'hDEAD_0BAD;
  typedef enum logic [2:0] {
    CDS_IDLE = 3'b001,
    CDS_CONV = 3'b010,
    CDS_DONE = 3'b100
  } cds_state_t;
endpackage : cds_pkg

// ---- cds_fifo_if.sv ----
// Interface: stream between the sequencer and its result FIFO
`timescale 1ns/10ps
interface cds_fifo_if #(parameter int W = 16) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
  modport user (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
endinterface : cds_fifo_if

// ---- cds_fifo.sv ----
// Module: result FIFO with valid/ready on both sides
`timescale 1ns/10ps
module cds_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  cds_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = f.in_valid && f.in_ready;
  wire pop = f.out_valid && f.out_ready;
  // Room left while the count is below the depth
  assign f.in_ready = (cnt_r < (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_r != '0);
  assign f.out_data = mem[rp_r];
  // Pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (ce && push) mem[wp_r] <= f.in_data;
  end
endmodule : cds_fifo

// ---- cds_seq.sv ----
// Module: four-channel sampling and readout sequencer with APB registers
// Function
// - CDS: reference captured on reference clock fall
// - CDS: data on data clock fall, difference
// - Four-channel: sample together, convert on falls
// - Result on bus three conversion cycles later
// - SHA: sample every channel on data fall
// - Input clamp disabled in SHA mode
// - Mux order from mux configuration register
// - Single-channel: mux stationary, one channel only
// - Four/single channel, CDS/SHA, register selected
// - Per-channel offset and gain applied
// - High byte bits 15-8, low byte 7-0
// - Mode bit low CDS, high SHA
// - Two-byte: MSB after rise, LSB after fall
// - Data clock pulse restarts mux at first
// - Single channel picked by mux bits 3 to 1
`timescale 1ns/10ps
module cds_seq
  import cds_pkg::*;
#(
  parameter int CH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reference_sample_clock,
  input wire logic data_sample_clock,
  input wire logic conversion_clock,
  input wire logic [CDS_DATA_W-1:0] chan_in [CH],
  output logic [7:0] out_bus,
  output logic out_valid,
  output logic clamp_enable,
  output logic fifo_overflow
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [2:0] pin_d_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r <= '0;
    end else if (ce) begin
      pin_s1_r <= {conversion_clock, data_sample_clock, reference_sample_clock};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  // Edge detect between the second and third stages
  wire ref_fall = pin_d_r[0] && !pin_s2_r[0];
  wire dat_fall = pin_d_r[1] && !pin_s2_r[1];
  wire cnv_fall = pin_d_r[2] && !pin_s2_r[2];
  wire cnv_rise = !pin_d_r[2] && pin_s2_r[2];

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [8:0] cfg_r;
  logic [8:0] mux_r;
  logic [CDS_GAIN_W-1:0] gain_r [CH];
  logic [CDS_OFS_W-1:0] offs_r [CH];
  logic [31:0] samples_r;
  cds_state_t st_r;
  cds_state_t st_nxt;
  wire [2:0] state_bits = st_r;
  wire sha_mode = cfg_r[CDS_CFG_SHA];
  wire single_mode = cfg_r[CDS_CFG_SINGLE];
  wire one_byte = cfg_r[CDS_CFG_ONEBYTE];
  wire powered = cfg_r[CDS_CFG_POWER];
  wire rev_order = mux_r[CDS_MUX_REV];

  // APB decode, zero wait states
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite;
  wire in_gain = paddr >= CDS_OFS_GAIN0 && paddr < CDS_OFS_OFFS0;
  wire in_offs = paddr >= CDS_OFS_OFFS0 && paddr < CDS_OFS_STAT;
  wire [1:0] gidx = 2'((paddr - CDS_OFS_GAIN0) >> 2);
  wire [1:0] oidx = 2'((paddr - CDS_OFS_OFFS0) >> 2);
  wire mapped = paddr[1:0] == 2'b00 && (paddr == CDS_OFS_CFG || paddr == CDS_OFS_MUX
    || in_gain || in_offs || paddr == CDS_OFS_STAT || paddr == CDS_OFS_SAMP);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = CDS_ERR_WORD;
    if (paddr == CDS_OFS_CFG) rd_mux = {23'h0, cfg_r};
    else if (paddr == CDS_OFS_MUX) rd_mux = {23'h0, mux_r};
    else if (in_gain) rd_mux = {26'h0, gain_r[gidx]};
    else if (in_offs) rd_mux = {23'h0, offs_r[oidx]};
    else if (paddr == CDS_OFS_STAT) rd_mux = {28'h0, state_bits, fifo_overflow};
    else if (paddr == CDS_OFS_SAMP) rd_mux = samples_r;
  end

  // Register writes; reserved bits stored as written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CDS_CFG_RST;
      mux_r <= CDS_MUX_RST;
      for (int i = 0; i < CH; i++) begin
        gain_r[i] <= '0;
        offs_r[i] <= '0;
      end
    end else if (ce && apb_wr && mapped) begin
      if (paddr == CDS_OFS_CFG) cfg_r <= pwdata[8:0];
      if (paddr == CDS_OFS_MUX) mux_r <= pwdata[8:0];
      if (in_gain) gain_r[gidx] <= pwdata[CDS_GAIN_W-1:0];
      if (in_offs) offs_r[oidx] <= pwdata[CDS_OFS_W-1:0];
    end
  end

  // APB answer registered, pready high from the first access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite && mapped) ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Front end sampling: all channels held together
  logic [CDS_DATA_W-1:0] refl_r [CH];
  logic [CDS_DATA_W-1:0] held_r [CH];
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_fe
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          refl_r[g] <= '0;
          held_r[g] <= '0;
        end else if (ce && powered) begin
          if (ref_fall && !sha_mode) refl_r[g] <= chan_in[g];
          if (dat_fall) held_r[g] <= sha_mode ? chan_in[g]
            : chan_in[g] - refl_r[g];
        end
      end
    end
  endgenerate

  // Offset (sign magnitude) then gain (1 + code/64 approx)
  function automatic logic [CDS_DATA_W-1:0] cds_cond(
    input logic [CDS_DATA_W-1:0] v,
    input logic [CDS_OFS_W-1:0] ofs,
    input logic [CDS_GAIN_W-1:0] gn);
    logic [CDS_DATA_W+1:0] s;
    logic [CDS_DATA_W+8:0] p;
    s = ofs[CDS_OFS_W-1] ? {2'b00, v} - {10'h0, ofs[7:0]} : {2'b00, v} + {10'h0, ofs[7:0]};
    if (s[CDS_DATA_W+1]) s = '0;
    else if (s[CDS_DATA_W]) s = {2'b00, {CDS_DATA_W{1'b1}}};
    p = {7'h0, s} * 25'(7'd64 + {1'b0, gn});
    p = p >> 6;
    cds_cond = (p[CDS_DATA_W+8:CDS_DATA_W] != '0) ? {CDS_DATA_W{1'b1}} : p[CDS_DATA_W-1:0];
  endfunction : cds_cond

  ////////////////////////////////////////////////////////////////////////
  // Multiplexer sequencing
  logic [1:0] slot_r;
  // First channel of a single-channel selection, A highest priority
  wire [1:0] single_ch = mux_r[3] ? 2'd0 : mux_r[2] ? 2'd1 : mux_r[1] ? 2'd2 : 2'd3;
  wire [1:0] first_ch = rev_order ? 2'd3 : 2'd0;
  wire [1:0] cur_ch = single_mode ? single_ch
    : (rev_order ? 2'd3 - slot_r : slot_r);
  // Only inside a pixel; extra conversion edges after the last slot are idle
  wire conv_now = cnv_fall && st_r == CDS_CONV && powered;
  wire last_slot = single_mode || slot_r == 2'd3;
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      CDS_IDLE: if (dat_fall && powered) st_nxt = CDS_CONV;
      CDS_CONV: if (conv_now && last_slot) st_nxt = CDS_DONE;
      CDS_DONE: if (dat_fall) st_nxt = CDS_CONV;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= CDS_IDLE;
      slot_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
      if (dat_fall) slot_r <= '0;
      else if (conv_now && !single_mode) slot_r <= slot_r + 2'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Three-cycle pipeline, shifted on conversion falls
  logic [CDS_DATA_W-1:0] pipe_r [CDS_LATENCY];
  logic [CDS_LATENCY-1:0] pv_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CDS_LATENCY; i++) pipe_r[i] <= '0;
      pv_r <= '0;
    end else if (ce && cnv_fall) begin
      pipe_r[0] <= cds_cond(held_r[cur_ch], offs_r[cur_ch], gain_r[cur_ch]);
      pv_r[0] <= conv_now;
      for (int i = 1; i < CDS_LATENCY; i++) begin
        pipe_r[i] <= pipe_r[i-1];
        pv_r[i] <= pv_r[i-1];
      end
    end
  end

  // Elastic buffer between pipeline and pins
  cds_fifo_if #(.W(CDS_DATA_W)) fq ();
  cds_fifo #(.W(CDS_DATA_W), .DEPTH(CDS_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .f(fq)
  );
  wire emit = cnv_fall && pv_r[CDS_LATENCY-1];
  assign fq.in_valid = emit;
  assign fq.in_data = pipe_r[CDS_LATENCY-1];
  // Pins drain one word per conversion rise; stalls when empty
  logic low_pend_r;
  logic [7:0] low_r;
  assign fq.out_ready = cnv_rise && !low_pend_r;

  ////////////////////////////////////////////////////////////////////////
  // Output bus and status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_bus <= '0;
      out_valid <= 1'b0;
      low_pend_r <= 1'b0;
      low_r <= '0;
      clamp_enable <= 1'b1;
      fifo_overflow <= 1'b0;
      samples_r <= '0;
    end else if (ce) begin
      clamp_enable <= !sha_mode;
      if (emit && !fq.in_ready) fifo_overflow <= 1'b1;
      else if (apb_wr && paddr == CDS_OFS_STAT && pwdata[0]) fifo_overflow <= 1'b0;
      if (fq.out_valid && fq.out_ready) begin
        out_bus <= fq.out_data[15:8];
        low_r <= fq.out_data[7:0];
        low_pend_r <= !one_byte;
        out_valid <= 1'b1;
        samples_r <= samples_r + 32'd1;
      end else if (cnv_fall && low_pend_r) begin
        out_bus <= low_r;
        low_pend_r <= 1'b0;
      end else if (cnv_rise) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : cds_seq

// ---- cds_seq_checker.sv ----
// Checker: port-level assertions for the sampling readout sequencer
`timescale 1ns/10ps
module cds_seq_checker
  import cds_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] out_bus,
  input wire logic out_valid,
  input wire logic clamp_enable
);
  wire cfg_wr;
  wire bad_addr;
  logic pwr_seen_r;
  // Completed config writes and holes in the map
  assign cfg_wr = psel && penable && pready && pwrite && paddr == CDS_OFS_CFG;
  assign bad_addr = paddr > CDS_OFS_SAMP || paddr[1:0] != 2'b00;
  // Power switched on at least once since reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_seen_r <= 1'b0;
    end else if (cfg_wr && pwdata[CDS_CFG_POWER]) begin
      pwr_seen_r <= 1'b1;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_ready_only: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_hole: assert property (psel && penable && bad_addr
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("hole not flagged");
  a_err_none: assert property (psel && penable && !bad_addr |-> !pslverr)
    else $error("error on mapped register");
  a_clamp_off: assert property (cfg_wr && pwdata[CDS_CFG_SHA] |-> ##[1:3] !clamp_enable)
    else $error("clamp left on in hold mode");
  a_clamp_on: assert property (cfg_wr && !pwdata[CDS_CFG_SHA] |-> ##[1:3] clamp_enable)
    else $error("clamp off in double sampling");
  a_sleep_quiet: assert property (!pwr_seen_r |-> !out_valid)
    else $error("output while never powered");
  a_ce_freeze: assert property (!ce |=> $stable(out_bus) && $stable(out_valid))
    else $error("output moved with enable low");
endmodule : cds_seq_checker

bind cds_seq cds_seq_checker i_cds_seq_checker (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .out_bus(out_bus), .out_valid(out_valid),
  .clamp_enable(clamp_enable));

// ---- cds_ctrl_model.sv ----
// Partner model: scanner controller making sample clocks, capturing bytes
`timescale 1ns/10ps
module cds_ctrl_model
  import cds_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic sha,
  input wire logic one_byte,
  input wire logic [7:0] out_bus,
  input wire logic out_valid,
  output logic reference_sample_clock,
  output logic data_sample_clock,
  output logic conversion_clock,
  output logic [CDS_DATA_W-1:0] chan_in [4],
  output logic done
);
  logic [7:0] byts [$];
  int first_cyc;
  // Levels from a base plus a per-channel step
  task automatic lv(input logic [15:0] b, input logic [15:0] s);
    for (int i = 0; i < 4; i++) begin
      chan_in[i] <= b + s * 16'(i);
    end
  endtask : lv
  // Bytes count only while flagged valid
  task automatic grab(input int k);
    if (out_valid === 1'b1) begin
      if (first_cyc < 0) first_cyc = k;
      byts.push_back(out_bus);
    end
  endtask : grab
  ////////////////////////////////////////
  // Link clocks stand still low between frames
  initial begin
    reference_sample_clock = 1'b0;
    data_sample_clock = 1'b0;
    conversion_clock = 1'b0;
    done = 1'b0;
    lv(16'hA5A5, 16'h0F0F);
    forever begin
      @(posedge clk);
      if (go && !done) begin
        byts.delete();
        first_cyc = -1;
        lv(16'h0100, 16'h0000);
        if (!sha) begin
          reference_sample_clock <= 1'b1;
          repeat (4) @(posedge clk);
          reference_sample_clock <= 1'b0;
          repeat (4) @(posedge clk);
        end
        lv(16'h1234, 16'h1000);
        data_sample_clock <= 1'b1;
        repeat (4) @(posedge clk);
        data_sample_clock <= 1'b0;
        repeat (4) @(posedge clk);
        // Levels move once held: a late sample sees junk
        lv(16'hA5A5, 16'h0F0F);
        for (int k = 0; k < 12; k++) begin
          conversion_clock <= 1'b1;
          repeat (8) @(posedge clk);
          grab(k);
          conversion_clock <= 1'b0;
          repeat (8) @(posedge clk);
          if (!one_byte) grab(k);
        end
        done <= 1'b1;
      end else if (!go) begin
        done <= 1'b0;
      end
    end
  end
endmodule : cds_ctrl_model

// ---- cds_tb.sv ----
// Testbench: APB set-up, one frame per mode, byte checks
`timescale 1ns/10ps
module tb
  import cds_pkg::*;
;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [CDS_DATA_W-1:0] chan_in [4];
  logic [7:0] out_bus;
  logic out_valid, clamp_enable, fifo_overflow, rclk, dclk, cclk, go, sha, one_byte, done;
  int errors, compares, cyc, ch, bi;
  logic [8:0] m_cfg [5] = '{9'h001, 9'h001, 9'h009, 9'h011, 9'h041};
  logic [8:0] m_mux [5] = '{9'h000, 9'h010, 9'h000, 9'h000, 9'h006};
  cds_seq #(.CH(4)) i_cds_seq (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reference_sample_clock(rclk), .data_sample_clock(dclk),
    .conversion_clock(cclk), .chan_in(chan_in), .out_bus(out_bus), .out_valid(out_valid),
    .clamp_enable(clamp_enable), .fifo_overflow(fifo_overflow));
  cds_ctrl_model i_cds_ctrl_model (.clk(clk), .go(go), .sha(sha), .one_byte(one_byte),
    .out_bus(out_bus), .out_valid(out_valid), .reference_sample_clock(rclk),
    .data_sample_clock(dclk), .conversion_clock(cclk), .chan_in(chan_in), .done(done));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, far above a full run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    {rst, ce, psel, penable, pwrite, go, sha, one_byte} = 8'hC0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CDS_OFS_CFG, 32'h0);
    chk(rd, 32'h0);
    chk(32'(clamp_enable), 32'h1);
    apb(1'b0, CDS_OFS_MUX, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, 12'h002, 32'hFFFF_FFFF);
    chk(32'(er), 32'h1);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    // Forward, reversed, hold with gain, one byte, single channel
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, CDS_OFS_CFG, 32'(m_cfg[m]));
      apb(1'b1, CDS_OFS_MUX, 32'(m_mux[m]));
      apb(1'b1, CDS_OFS_GAIN0, (m == 2) ? 32'h20 : 32'h0);
      sha <= m_cfg[m][CDS_CFG_SHA];
      one_byte <= m_cfg[m][CDS_CFG_ONEBYTE];
      go <= 1'b1;
      while (done !== 1'b1) @(posedge clk);
      go <= 1'b0;
      chk(32'(clamp_enable), 32'(!m_cfg[m][CDS_CFG_SHA]));
      for (int j = 0; j < (m_cfg[m][CDS_CFG_SINGLE] ? 1 : 4); j++) begin
        ch = m_cfg[m][CDS_CFG_SINGLE] ? 1 : (m_mux[m][CDS_MUX_REV] ? 3 - j : j);
        v = 32'h1234 + 32'h1000 * ch - (m_cfg[m][CDS_CFG_SHA] ? 32'h0 : 32'h100);
        v = (m == 2 && ch == 0) ? v + v * 32 / 64 : v;
        bi = m_cfg[m][CDS_CFG_ONEBYTE] ? j : 2 * j;
        chk(32'(i_cds_ctrl_model.byts[bi]), v[15:8]);
        if (!m_cfg[m][CDS_CFG_ONEBYTE]) chk(32'(i_cds_ctrl_model.byts[bi + 1]), v[7:0]);
      end
      if (m == 0) chk(i_cds_ctrl_model.first_cyc, 32'h4);
    end
    apb(1'b0, CDS_OFS_CFG, 32'h0);
    chk(rd, 32'h41);
    chk(32'(fifo_overflow), 32'h0);
    apb(1'b0, CDS_OFS_STAT, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, CDS_OFS_SAMP, 32'h0);
    chk(rd, 32'd17);
    wrap_up();
  end
endmodule : tb
